// ---- pkg/swl_consts.svh ----
// Timing constants for the single-wire slot signalling link.
// Assumes a 20 MHz system clock on both ends.
// Function
// - Falling is active, rising is idle
// - Reset then presence starts every exchange
// - Slew-limited host lengthens reset low
// - Device waits, then drives presence low
// - Host samples presence at fixed time
// - One bit per time slot
// - Device slot timer starts on fall
// - Write-one released before max low time
// - Write-zero held past min low time
// - Host keeps low below input-low level
// - Host waits recovery before next slot
// - Read slot starts like write-one
// - Device drives zero, never drives one
// - Host samples inside read window
// - Host waits full slot after read
// - Longer recovery with several slaves
// - Hysteresis rejects shallow negative glitches
// - Overdrive speed only
// - Least significant bit first
// - Bus idles high between transactions
// - Host makes every falling edge but presence
`ifndef SWL_CONSTS_SVH
`define SWL_CONSTS_SVH

`define SWL_CLK_MHZ 20
// Times in ns, counts in 50 ns cycles
`define SWL_RESET_LOW_NS 48000
`define SWL_RESET_LOW_CYC (`SWL_RESET_LOW_NS * `SWL_CLK_MHZ / 1000)
`define SWL_RESET_DET_NS 16000
`define SWL_RESET_DET_CYC (`SWL_RESET_DET_NS * `SWL_CLK_MHZ / 1000)
`define SWL_PRES_WAIT_NS 2000
`define SWL_PRES_WAIT_CYC (`SWL_PRES_WAIT_NS * `SWL_CLK_MHZ / 1000)
`define SWL_PRES_LOW_NS 8000
`define SWL_PRES_LOW_CYC (`SWL_PRES_LOW_NS * `SWL_CLK_MHZ / 1000)
`define SWL_PRES_SAMP_NS 8500
`define SWL_PRES_SAMP_CYC (`SWL_PRES_SAMP_NS * `SWL_CLK_MHZ / 1000)
`define SWL_INIT_END_NS 48000
`define SWL_INIT_END_CYC (`SWL_INIT_END_NS * `SWL_CLK_MHZ / 1000)
`define SWL_W1L_NS 1000
`define SWL_W1L_CYC (`SWL_W1L_NS * `SWL_CLK_MHZ / 1000)
`define SWL_W0L_NS 8000
`define SWL_W0L_CYC (`SWL_W0L_NS * `SWL_CLK_MHZ / 1000)
`define SWL_WSAMP_NS 4000
`define SWL_WSAMP_CYC (`SWL_WSAMP_NS * `SWL_CLK_MHZ / 1000)
`define SWL_RL_NS 1000
`define SWL_RL_CYC (`SWL_RL_NS * `SWL_CLK_MHZ / 1000)
`define SWL_RHOLD_NS 3000
`define SWL_RHOLD_CYC (`SWL_RHOLD_NS * `SWL_CLK_MHZ / 1000)
`define SWL_MSR_NS 2000
`define SWL_MSR_CYC (`SWL_MSR_NS * `SWL_CLK_MHZ / 1000)
`define SWL_SLOT_NS 13000
`define SWL_SLOT_CYC (`SWL_SLOT_NS * `SWL_CLK_MHZ / 1000)
`define SWL_REC_NS 2000
`define SWL_REC_CYC (`SWL_REC_NS * `SWL_CLK_MHZ / 1000)
`define SWL_GLITCH_CYC 2
`define SWL_CNT_W 12

`endif

// ---- pkg/swl_pkg.sv ----
// Types shared by both ends of the single-wire link.
// Assumes swl_consts.svh sits on the include path.
`include "swl_consts.svh"
package swl_pkg;
    typedef enum logic [1:0] {
        SWL_OP_RESET,
        SWL_OP_WRITE,
        SWL_OP_READ
    } swl_op_t;
    typedef logic [`SWL_CNT_W-1:0] swl_cnt_t;
endpackage : swl_pkg

// ---- pkg/swl_if.sv ----
// Single open-drain wire joining host and device.
// Each end drives low only; the bench resolves the wire level.
`timescale 1ns/1ns
interface swl_if;
    logic line_in;
    logic host_oe;
    logic dev_oe;
    logic host_out;
    logic dev_out;
    modport host (input line_in, output host_oe, output host_out);
    modport dev (input line_in, output dev_oe, output dev_out);
endinterface : swl_if

// ---- rtl/swl_device.sv ----
// Device end: reset/presence detection, write sampling, read driving.
// Assumes swl_if line_in is the wired-AND of both pull-downs.
`timescale 1ns/1ns
`include "swl_consts.svh"
module swl_device #(
    parameter int RESET_DET_CYC = `SWL_RESET_DET_CYC,
    parameter int PRES_WAIT_CYC = `SWL_PRES_WAIT_CYC,
    parameter int PRES_LOW_CYC = `SWL_PRES_LOW_CYC
) (
    input wire logic clk,
    input wire logic rst_b,
    swl_if.dev wire_io,
    input wire logic tx_bit,
    output logic tx_take,
    output logic rx_valid,
    output logic rx_bit,
    output logic bus_reset,
    output logic presence_done
);
    import swl_pkg::*;

    typedef enum logic [2:0] {
        SWL_D_IDLE, SWL_D_LOW, SWL_D_PWAIT, SWL_D_PRES, SWL_D_REC
    } swl_dstate_t;

    // ==========================================================
    // Input synchroniser and hysteresis filter
    // ==========================================================
    logic sync1_q, sync2_q;
    logic line_q;
    logic [1:0] flt_q;
    always_ff @(posedge clk) begin
        sync1_q <= wire_io.line_in;
        sync2_q <= sync1_q;
    end
    // falling hysteresis: a short low dip is ignored
    wire flt_agree = (sync2_q == line_q);
    wire flt_done = (flt_q == 2'(`SWL_GLITCH_CYC - 1));
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            line_q <= 1'b1;
            flt_q <= '0;
        end else if (flt_agree) begin
            flt_q <= '0;
        end else if (flt_done || line_q == 1'b0) begin
            // rise accepted at once, fall after filter
            line_q <= sync2_q;
            flt_q <= '0;
        end else begin
            flt_q <= flt_q + 2'h1;
        end
    end
    wire fall = line_q && !sync2_q && flt_done;
    wire rise = !line_q && sync2_q;

    // ==========================================================
    // Slot state machine
    // ==========================================================
    swl_dstate_t st_q, st_d;
    swl_cnt_t cnt_q, cnt_d;
    logic drive_q, drive_d;
    logic bit_q, bit_d;
    logic rxv_d, rxb_d, rxb_q, rxv_q, rst_d, rst_q, pd_d, pd_q, take_d;

    wire reset_seen = (st_q == SWL_D_LOW) &&
                      (cnt_q >= swl_cnt_t'(RESET_DET_CYC));
    wire samp_pt = (cnt_q == swl_cnt_t'(`SWL_WSAMP_CYC));
    wire samp_past = (cnt_q > swl_cnt_t'(`SWL_WSAMP_CYC));
    wire in_rec = (st_q == SWL_D_REC);

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q + 12'h001;
        drive_d = drive_q;
        bit_d = bit_q;
        rxv_d = 1'b0;
        rxb_d = rxb_q;
        rst_d = 1'b0;
        pd_d = 1'b0;
        take_d = 1'b0;
        case (st_q)
            SWL_D_IDLE, SWL_D_REC: begin
                // Keep timing a write-one slot up to its sample point
                cnt_d = (in_rec && !samp_past) ? cnt_q + 12'h001 : cnt_q;
                // write-one rises before the sample point
                if (in_rec && samp_pt && bit_q) begin
                    rxv_d = 1'b1;
                    rxb_d = line_q;
                end
                // host fall starts the slot timer
                if (fall) begin
                    st_d = SWL_D_LOW;
                    cnt_d = '0;
                    bit_d = tx_bit;
                    take_d = 1'b1;
                    drive_d = !tx_bit;
                end
            end
            SWL_D_LOW: begin
                // release when the slot timer reaches the read hold time
                if (cnt_q == swl_cnt_t'(`SWL_RHOLD_CYC)) begin
                    drive_d = 1'b0;
                end
                // one bit sampled per write slot
                if (samp_pt && bit_q) begin
                    rxv_d = 1'b1;
                    rxb_d = line_q;
                end
                if (reset_seen) begin
                    drive_d = 1'b0;
                    // Step once past the threshold so the pulse is single
                    cnt_d = (cnt_q == swl_cnt_t'(RESET_DET_CYC)) ?
                        cnt_q + 12'h001 : cnt_q;
                    rst_d = (cnt_q == swl_cnt_t'(RESET_DET_CYC));
                end
                if (rise) begin
                    cnt_d = reset_seen ? '0 : cnt_q + 12'h001;
                    drive_d = 1'b0;
                    st_d = reset_seen ? SWL_D_PWAIT : SWL_D_REC;
                end
            end
            SWL_D_PWAIT: begin
                if (cnt_q == swl_cnt_t'(PRES_WAIT_CYC - 1)) begin
                    st_d = SWL_D_PRES;
                    cnt_d = '0;
                    drive_d = 1'b1;
                end else if (fall) begin
                    st_d = SWL_D_LOW;
                    cnt_d = '0;
                end
            end
            SWL_D_PRES: begin
                if (cnt_q == swl_cnt_t'(PRES_LOW_CYC - 1)) begin
                    drive_d = 1'b0;
                    pd_d = 1'b1;
                    st_d = SWL_D_IDLE;
                    cnt_d = '0;
                end
            end
            default: begin
                st_d = SWL_D_IDLE;
                drive_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st_q <= SWL_D_IDLE;
            cnt_q <= '0;
            drive_q <= 1'b0;
            bit_q <= 1'b1;
            rxv_q <= 1'b0;
            rxb_q <= 1'b0;
            rst_q <= 1'b0;
            pd_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            drive_q <= drive_d;
            bit_q <= bit_d;
            rxv_q <= rxv_d;
            rxb_q <= rxb_d;
            rst_q <= rst_d;
            pd_q <= pd_d;
        end
    end

    // Device pulls low while drive_q is set, for presence and read zero
    assign wire_io.dev_oe = drive_q;
    assign wire_io.dev_out = 1'b0;
    assign tx_take = take_d;
    assign rx_valid = rxv_q;
    assign rx_bit = rxb_q;
    assign bus_reset = rst_q;
    assign presence_done = pd_q;
endmodule : swl_device

// ---- rtl/swl_host.sv ----
// Host end: drives reset, write and read slots on the single wire.
// Assumes the device end and a pull-up resolve the wire level.
`timescale 1ns/1ns
`include "swl_consts.svh"
module swl_host #(
    parameter int RESET_LOW_CYC = `SWL_RESET_LOW_CYC,
    parameter int INIT_END_CYC = `SWL_INIT_END_CYC,
    parameter int REC_CYC = `SWL_REC_CYC
) (
    input wire logic clk,
    input wire logic rst_b,
    swl_if.host wire_io,
    input wire logic req_valid,
    input wire swl_pkg::swl_op_t req_op,
    input wire logic req_bit,
    output logic req_ready,
    output logic resp_valid,
    output logic resp_bit
);
    import swl_pkg::*;

    typedef enum logic [2:0] {
        SWL_H_IDLE, SWL_H_LOW, SWL_H_WAIT, SWL_H_REC
    } swl_hstate_t;

    // ==========================================================
    // Line synchroniser
    // ==========================================================
    logic sync1_q, sync2_q;
    always_ff @(posedge clk) begin
        sync1_q <= wire_io.line_in;
        sync2_q <= sync1_q;
    end

    // ==========================================================
    // Slot sequencer
    // ==========================================================
    swl_hstate_t st_q;
    swl_op_t op_q;
    swl_cnt_t cnt_q, low_q, samp_q, end_q;
    logic drive_q, rv_q, rb_q;

    // low time per operation, reset carries margin
    wire swl_cnt_t low_len = (req_op == SWL_OP_RESET) ?
        swl_cnt_t'(RESET_LOW_CYC + 1) :
        (req_op == SWL_OP_READ) ? swl_cnt_t'(`SWL_RL_CYC) :
        req_bit ? swl_cnt_t'(`SWL_W1L_CYC) : swl_cnt_t'(`SWL_W0L_CYC);
    // sample points from release or fall
    wire swl_cnt_t samp_at = (req_op == SWL_OP_RESET) ?
        swl_cnt_t'(`SWL_PRES_SAMP_CYC) : swl_cnt_t'(`SWL_MSR_CYC);
    // full slot or init window before next
    wire swl_cnt_t end_at = (req_op == SWL_OP_RESET) ?
        swl_cnt_t'(INIT_END_CYC) : swl_cnt_t'(`SWL_SLOT_CYC);
    wire low_done = (cnt_q == low_q - 12'h001);
    wire samp_hit = (cnt_q == samp_q) && (op_q != SWL_OP_WRITE);

    assign req_ready = (st_q == SWL_H_IDLE) && rst_b;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st_q <= SWL_H_IDLE;
            op_q <= SWL_OP_WRITE;
            cnt_q <= '0;
            low_q <= '0;
            samp_q <= '0;
            end_q <= '0;
            drive_q <= 1'b0;
            rv_q <= 1'b0;
            rb_q <= 1'b0;
        end else begin
            rv_q <= 1'b0;
            case (st_q)
                SWL_H_IDLE: begin
                    if (req_valid) begin
                        st_q <= SWL_H_LOW;
                        op_q <= req_op;
                        low_q <= low_len;
                        samp_q <= samp_at;
                        end_q <= end_at;
                        cnt_q <= '0;
                        drive_q <= 1'b1;
                    end
                end
                SWL_H_LOW: begin
                    cnt_q <= cnt_q + 12'h001;
                    if (low_done) begin
                        drive_q <= 1'b0;
                        if (op_q == SWL_OP_RESET) begin
                            cnt_q <= '0;
                        end
                        st_q <= SWL_H_WAIT;
                    end
                end
                SWL_H_WAIT: begin
                    cnt_q <= cnt_q + 12'h001;
                    if (samp_hit) begin
                        rv_q <= 1'b1;
                        rb_q <= (op_q == SWL_OP_RESET) ? !sync2_q : sync2_q;
                    end
                    if (cnt_q >= end_q) begin
                        st_q <= SWL_H_REC;
                        cnt_q <= '0;
                    end
                end
                SWL_H_REC: begin
                    cnt_q <= sync2_q ? cnt_q + 12'h001 : '0;
                    if (cnt_q == swl_cnt_t'(REC_CYC - 1)) begin
                        st_q <= SWL_H_IDLE;
                    end
                end
                default: begin
                    st_q <= SWL_H_IDLE;
                    drive_q <= 1'b0;
                end
            endcase
        end
    end

    assign wire_io.host_oe = drive_q;
    assign wire_io.host_out = 1'b0;
    assign resp_valid = rv_q;
    assign resp_bit = rb_q;
endmodule : swl_host

// ---- bench/swl_chk.sv ----
// Concurrent checks on the shared wire of the single-wire link.
// Assumes the bench instantiates it beside swl_if, by name.
`timescale 1ns/1ns
`include "swl_consts.svh"
module swl_chk #(
    parameter int RESET_DET_CYC = `SWL_RESET_DET_CYC,
    parameter int RESET_LOW_CYC = `SWL_RESET_LOW_CYC
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic host_oe,
    input wire logic dev_oe
);
    localparam int PW_LO = `SWL_PRES_WAIT_CYC - 2;
    localparam int PW_HI = `SWL_PRES_WAIT_CYC + 12;
    localparam int PL = `SWL_PRES_LOW_CYC;
    localparam int RH = `SWL_RHOLD_CYC;
    localparam int W1 = `SWL_W1L_CYC;
    localparam int W0 = `SWL_W0L_CYC;
    // ==========================================
    // Run lengths, saturating so idle never wraps
    logic [11:0] h_q, d_q, idle_q, slot_q;
    logic pres_q, seen_q;
    wire long_low = h_q >= 12'(RESET_DET_CYC);
    wire dev_fell = !dev_oe && d_q != 12'h000;
    function automatic logic [11:0] inc(input logic [11:0] v);
        return (v == 12'hFFF) ? v : v + 12'h001;
    endfunction : inc
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            h_q <= 12'h000;
            d_q <= 12'h000;
            idle_q <= 12'h000;
            slot_q <= 12'h000;
            pres_q <= 1'b0;
            seen_q <= 1'b0;
        end else begin
            h_q <= host_oe ? inc(h_q) : 12'h000;
            d_q <= dev_oe ? inc(d_q) : 12'h000;
            idle_q <= (host_oe | dev_oe) ? 12'h000 : inc(idle_q);
            slot_q <= $rose(host_oe) ? 12'h001 : inc(slot_q);
            pres_q <= (!host_oe && long_low) | (pres_q & !dev_fell);
            seen_q <= seen_q | host_oe;
        end
    end
    // ==========================================
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    a_pres_delay: assert property (
        ($fell(host_oe) && long_low) |-> ##[PW_LO:PW_HI] $rose(dev_oe))
        else $error("presence pulse late or missing");
    a_pres_width: assert property (
        ($fell(dev_oe) && pres_q) |-> d_q inside {[PL - 2:PL + 2]})
        else $error("presence pulse width wrong");
    a_dev_origin: assert property (
        ($rose(dev_oe) && !pres_q) |-> host_oe)
        else $error("device began a low on an idle line");
    a_read_hold: assert property (
        ($fell(dev_oe) && !pres_q) |-> d_q inside {[RH - 3:RH + 3]})
        else $error("read zero hold wrong");
    a_host_low: assert property (
        $fell(host_oe) |-> h_q inside {[W1 - 1:W1 + 1], [W0 - 1:W0 + 1],
            [RESET_LOW_CYC:RESET_LOW_CYC + 2]})
        else $error("host low time wrong");
    a_host_recov: assert property (
        ($rose(host_oe) && seen_q) |-> idle_q >= 12'(`SWL_REC_CYC))
        else $error("recovery too short");
    a_slot_len: assert property (
        ($rose(host_oe) && seen_q) |-> slot_q >= 12'(`SWL_SLOT_CYC))
        else $error("slot too short");
    a_pres_quiet: assert property (
        (pres_q && dev_oe) |-> !host_oe)
        else $error("host drove during presence");
endmodule : swl_chk

// ---- bench/swl_test.sv ----
// Self-checking bench: host and device joined across swl_if.
// Assumes pkg/ on the include path and the package compiled first.
`timescale 1ns/1ns
`include "swl_consts.svh"
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin error_cnt++; \
    $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module swl_test;
    import swl_pkg::*;
    logic clk, rst_b, req_valid, req_bit, req_ready, resp_valid, resp_bit;
    logic tx_bit, tx_take, rx_valid, rx_bit, bus_reset, presence_done;
    logic glitch, dev_en, r;
    swl_op_t req_op;
    int error_cnt = 0;
    int tests_run = 0;
    int takes = 0;
    int resets = 0;
    int pres = 0;
    logic rxq[$];
    logic [7:0] d;
    // ==========================================
    // Wire: dev_en unplugs the device, glitch is noise
    swl_if link();
    assign link.line_in = ~(link.host_oe | (link.dev_oe & dev_en) | glitch);
    swl_host #(.RESET_LOW_CYC(400), .INIT_END_CYC(400)) swl_host_i (
        .clk(clk), .rst_b(rst_b), .wire_io(link), .req_valid(req_valid),
        .req_op(req_op), .req_bit(req_bit), .req_ready(req_ready),
        .resp_valid(resp_valid), .resp_bit(resp_bit));
    swl_device #(.RESET_DET_CYC(200)) swl_device_i (
        .clk(clk), .rst_b(rst_b), .wire_io(link), .tx_bit(tx_bit),
        .tx_take(tx_take), .rx_valid(rx_valid), .rx_bit(rx_bit),
        .bus_reset(bus_reset), .presence_done(presence_done));
    swl_chk #(.RESET_DET_CYC(200), .RESET_LOW_CYC(400)) swl_chk_i (
        .clk(clk), .rst_b(rst_b), .host_oe(link.host_oe),
        .dev_oe(link.dev_oe));
    // ==========================================
    // Clock, monitors, helpers
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        if (rx_valid === 1'b1) rxq.push_back(rx_bit);
        takes += int'(tx_take === 1'b1);
        resets += int'(bus_reset === 1'b1);
        pres += int'(presence_done === 1'b1);
    end
    // A zero comes back only if the device can pull the wire
    function automatic logic exp_read(input logic tx, input logic en);
        return tx | ~en;
    endfunction : exp_read
    task automatic wait_for(ref logic s);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (s !== 1'b1 && n < 9000);
        if (s !== 1'b1) error_cnt++;
    endtask : wait_for
    task automatic run_op(input swl_op_t o, input logic b);
        @(negedge clk);
        req_valid = 1'b1;
        req_op = o;
        req_bit = b;
        wait_for(req_ready);
        @(negedge clk);
        req_valid = 1'b0;
        if (o != SWL_OP_WRITE) begin
            wait_for(resp_valid);
            r = resp_bit;
        end
        @(negedge clk);
        wait_for(req_ready);
    endtask : run_op
    task automatic do_reset(input logic en);
        int r0;
        int p0;
        r0 = resets;
        p0 = pres;
        @(negedge clk);
        dev_en = en;
        run_op(SWL_OP_RESET, 1'b0);
        `CHK(r, en);
        `CHK(resets - r0, 1);
        `CHK(pres - p0, 1);
    endtask : do_reset
    task automatic conclude();
        if (error_cnt == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : conclude
    initial begin
        #(60000 * 50);
        error_cnt++;
        conclude();
    end
    // ==========================================
    // Main sequence
    initial begin
        rst_b = 1'b0;
        req_valid = 1'b0;
        req_op = SWL_OP_RESET;
        req_bit = 1'b0;
        tx_bit = 1'b1;
        glitch = 1'b0;
        dev_en = 1'b1;
        void'($urandom(26470));
        repeat (2) @(negedge clk);
        rst_b = 1'b1;
        do_reset(1'b1);
        do_reset(1'b0);
        do_reset(1'b1);
        for (int k = 0; k < 6; k++) begin
            d = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : 8'($urandom);
            rxq.delete();
            for (int i = 0; i < 8; i++) run_op(SWL_OP_WRITE, d[i]);
            `CHK(rxq.size(), 8);
            for (int i = 0; i < 8; i++) `CHK(rxq.pop_front(), d[i]);
        end
        for (int k = 0; k < 16; k++) begin
            int t0;
            t0 = takes;
            @(negedge clk);
            tx_bit = 1'($urandom);
            run_op(SWL_OP_READ, 1'b1);
            `CHK(r, exp_read(tx_bit, 1'b1));
            `CHK(takes - t0, 1);
        end
        // Short dip while idle must not open a slot
        rxq.delete();
        @(negedge clk);
        tx_bit = 1'b1;
        glitch = 1'b1;
        @(negedge clk);
        glitch = 1'b0;
        run_op(SWL_OP_WRITE, 1'b0);
        `CHK(rxq.size(), 1);
        `CHK(rxq.pop_front(), 1'b0);
        @(negedge clk);
        rst_b = 1'b0;
        repeat (2) @(negedge clk);
        rst_b = 1'b1;
        do_reset(1'b1);
        conclude();
    end
endmodule : swl_test
